// ### design/sync_serial_pkg.sv
// Shared constants, field layouts and types of the synchronous serial port
package sync_serial_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] CTRL_ZERO_ADDR      = 32'h4004_0000;
    localparam logic [31:0] FIFO_STATE_ADDR     = 32'h4004_000c;
    localparam logic [31:0] PRESCALE_ADDR       = 32'h4004_0010;
    localparam logic [31:0] IRQ_ENABLE_ADDR     = 32'h4004_0014;
    localparam logic [31:0] RAW_COND_ADDR       = 32'h4004_0018;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TX_EMPTY_BIT   = 0;
    localparam int TX_ROOM_BIT    = 1;
    localparam int RX_DATA_BIT    = 2;
    localparam int RX_FULL_BIT    = 3;
    localparam int LINK_BUSY_BIT  = 4;
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_SLAVE_BIT = 1;
    localparam int CTRL_RATE_LSB  = 8;
    localparam int COND_OVERRUN   = 0;
    localparam int COND_TIMEOUT   = 1;
    localparam int COND_RX_HALF   = 2;
    localparam int COND_TX_HALF   = 3;
    localparam int NUM_COND       = 4;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0] PRESCALE_RESET   = 8'h00;
    localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;
    localparam logic [7:0] RATE_RESET       = 8'h00;
    localparam int         TIMEOUT_BITS     = 32;
    // Generator ticks twice per bit period
    localparam int         TIMEOUT_TICKS    = 2 * TIMEOUT_BITS;

    typedef struct packed {
        logic [7:0] rate;
        logic       slave;
        logic       enable;
    } ctrl_t;

    typedef struct packed {
        logic busy;
        logic rx_full;
        logic rx_has_data;
        logic tx_has_room;
        logic tx_empty;
    } status_t;

    typedef enum logic [0:0] {
        ST_IDLE  = 1'b0,
        ST_SHIFT = 1'b1
    } engine_state_t;

endpackage

// ### design/sync_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and newest-entry overwrite
module sync_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [W-1:0]               in_data,
    input  wire logic                       in_overwrite,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [W-1:0]                    out_data,
    output logic [$clog2(DEPTH):0]          level
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0]   count_q;
    logic [AW:0]   count_d;
    logic          full_q;
    logic          valid_q;
    logic          push;
    logic          pop;
    logic          over;

    assign push      = in_valid && !full_q;
    assign pop       = valid_q && out_ready;
    assign over      = in_valid && in_overwrite && full_q;
    assign in_ready  = !full_q;
    assign out_valid = valid_q;
    assign out_data  = mem_q[rd_ptr_q];
    assign level     = count_q;
    assign count_d   = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end else if (over) begin
            mem_q[wr_ptr_q - 1'b1] <= in_data;
        end
    end

    // ------------------------------------------------------------
    // Pointers and flags
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
            full_q   <= 1'b0;
            valid_q  <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_d;
            full_q  <= (count_d == DEPTH[AW:0]);
            valid_q <= (count_d != '0);
        end
    end
endmodule

// ### design/sync_serial_port.sv
// Synchronous serial port: status, prescaler, interrupt enables, shift engine
//
// Behaviour
// [RQ1] Status bit 0 set when transmit FIFO empty
// [RQ2] Status bit 1 clear when transmit FIFO full
// [RQ3] Status bit 2 set when receive FIFO holds data
// [RQ4] Status bit 3 set when receive FIFO full
// [RQ5] Status bit 4 set while shifting or transmit pending
// [RQ6] Status register read-only, live, upper bits reserved
// [RQ7] Prescaler divides clock by even divisor 2..254
// [RQ8] Divisor bit 0 always reads zero
// [RQ9] Bit clock further divided by rate factor
// [RQ10] Software sets divisor before any transmission
// [RQ11] External slave clock at most one twelfth
// [RQ12] Slave mode ignores divisor, uses external clock
// [RQ13] Four enable bits, one per condition, reset zero
// [RQ14] Frame into full receive FIFO flags overrun, replaces
// [RQ15] Unread non-empty receive FIFO for 32 bits times out
// [RQ16] Receive condition when FIFO at least half full
// [RQ17] Transmit condition when FIFO at least half empty
// [RQ18] Timeout count restarts on read, write, empty
module sync_serial_port
    import sync_serial_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int DEPTH  = 8
) (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic [31:0]                 avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [31:0]                 avs_writedata,
    input  wire logic [3:0]                  avs_byteenable,
    output logic [31:0]                      avs_readdata,
    output logic                             avs_waitrequest,
    input  wire logic                        tx_in_valid,
    output logic                             tx_in_ready,
    input  wire logic [DATA_W-1:0]           tx_in_data,
    output logic                             rx_out_valid,
    input  wire logic                        rx_out_ready,
    output logic [DATA_W-1:0]                rx_out_data,
    input  wire logic                        serial_clk_in,
    output logic                             serial_clk_out,
    output logic                             serial_clk_oe,
    input  wire logic                        serial_sel_n_in,
    output logic                             serial_sel_n_out,
    output logic                             serial_sel_oe,
    input  wire logic                        serial_data_in,
    output logic                             serial_data_out,
    output logic                             serial_data_oe,
    output logic                             irq_request
);
    import sync_serial_pkg::*;

    localparam int BW = $clog2(DATA_W) + 1;
    localparam int LW = $clog2(DEPTH) + 1;

    ctrl_t            ctrl_q;
    logic [7:1]       prescale_q;
    logic [3:0]       irq_enable_q;
    logic             overrun_q;
    logic             irq_q;
    logic             wait_q;
    logic [31:0]      rdata_q;
    engine_state_t    state_q;
    logic [BW-1:0]    bit_cnt_q;
    logic [DATA_W-1:0] tx_sh_q;
    logic [DATA_W-1:0] rx_sh_q;
    logic             sclk_q;
    logic             sel_n_q;
    logic             dout_q;
    logic             clk_oe_q;
    logic             data_oe_q;
    logic [6:0]       pre_cnt_q;
    logic [7:0]       rate_cnt_q;
    logic [6:0]       to_cnt_q;
    logic [2:0]       sck_sync_q;
    logic [1:0]       sel_sync_q;
    logic [1:0]       din_sync_q;

    logic             tx_valid;
    logic [DATA_W-1:0] tx_data;
    logic             tx_pop;
    logic             rx_full_n;
    logic             rx_pop;
    logic [LW-1:0]    tx_level;
    logic [LW-1:0]    rx_level;
    logic             pre_tick;
    logic             half_tick;
    logic             rise_ev;
    logic             fall_ev;
    logic             start;
    logic             frame_done;
    logic             sel_active;
    logic             access;
    logic             wr_en;
    status_t          status;
    logic [3:0]       raw_cond;

    // ------------------------------------------------------------
    // Data FIFOs
    // ------------------------------------------------------------
    sync_fifo #(
        .W     (DATA_W),
        .DEPTH (DEPTH)
    ) u_tx_fifo (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .in_valid     (tx_in_valid),
        .in_ready     (tx_in_ready),
        .in_data      (tx_in_data),
        .in_overwrite (1'b0),
        .out_valid    (tx_valid),
        .out_ready    (tx_pop),
        .out_data     (tx_data),
        .level        (tx_level)
    );

    // [RQ14] Overwrite newest entry
    sync_fifo #(
        .W     (DATA_W),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .in_valid     (frame_done),
        .in_ready     (rx_full_n),
        .in_data      (rx_sh_q),
        .in_overwrite (1'b1),
        .out_valid    (rx_out_valid),
        .out_ready    (rx_out_ready),
        .out_data     (rx_out_data),
        .level        (rx_level)
    );

    assign rx_pop = rx_out_valid && rx_out_ready;

    // ------------------------------------------------------------
    // Live status and conditions
    // ------------------------------------------------------------
    always_comb begin
        // [RQ1] Transmit empty
        status.tx_empty    = !tx_valid;
        // [RQ2] Transmit room
        status.tx_has_room = tx_in_ready;
        // [RQ3] Receive data present
        status.rx_has_data = rx_out_valid;
        // [RQ4] Receive full
        status.rx_full     = !rx_full_n;
        // [RQ5] Busy while shifting
        status.busy        = (state_q != ST_IDLE) || tx_valid;
    end

    always_comb begin
        raw_cond = '0;
        raw_cond[COND_OVERRUN] = overrun_q;
        // [RQ15] Timeout reached
        raw_cond[COND_TIMEOUT] = (to_cnt_q == 7'(TIMEOUT_TICKS));
        // [RQ16] Receive half full
        raw_cond[COND_RX_HALF] = (rx_level >= LW'(DEPTH / 2));
        // [RQ17] Transmit half empty
        raw_cond[COND_TX_HALF] = (tx_level <= LW'(DEPTH / 2));
    end

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    assign access = (avs_read || avs_write) && wait_q;
    assign wr_en  = avs_write && !wait_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !access;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= '0;
        end else if (access) begin
            rdata_q <= '0;
            if (avs_read) begin
                unique case (avs_address)
                    CTRL_ZERO_ADDR: begin
                        rdata_q[CTRL_RATE_LSB +: 8] <= ctrl_q.rate;
                        rdata_q[CTRL_SLAVE_BIT]     <= ctrl_q.slave;
                        rdata_q[CTRL_EN_BIT]        <= ctrl_q.enable;
                    end
                    // [RQ6] Reserved bits zero
                    FIFO_STATE_ADDR: rdata_q[4:0] <= status;
                    // [RQ8] Even divisor readback
                    PRESCALE_ADDR:   rdata_q[7:0] <= {prescale_q, 1'b0};
                    IRQ_ENABLE_ADDR: rdata_q[3:0] <= irq_enable_q;
                    RAW_COND_ADDR:   rdata_q[3:0] <= raw_cond;
                    default:         rdata_q      <= '0;
                endcase
            end
        end
    end

    // [RQ6] Status ignores writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_q <= '{rate: RATE_RESET, slave: 1'b0, enable: 1'b0};
        end else if (wr_en && avs_address == CTRL_ZERO_ADDR) begin
            if (avs_byteenable[0]) begin
                ctrl_q.enable <= avs_writedata[CTRL_EN_BIT];
                if (state_q == ST_IDLE) begin
                    ctrl_q.slave <= avs_writedata[CTRL_SLAVE_BIT];
                end
            end
            if (avs_byteenable[1]) begin
                ctrl_q.rate <= avs_writedata[CTRL_RATE_LSB +: 8];
            end
        end
    end

    // [RQ7] Divisor storage
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prescale_q <= PRESCALE_RESET[7:1];
        end else if (wr_en && avs_address == PRESCALE_ADDR && avs_byteenable[0]) begin
            // [RQ8] Bit zero dropped
            prescale_q <= avs_writedata[7:1];
        end
    end

    // [RQ13] Enable bits
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_enable_q <= IRQ_ENABLE_RESET;
        end else if (wr_en && avs_address == IRQ_ENABLE_ADDR && avs_byteenable[0]) begin
            irq_enable_q <= avs_writedata[NUM_COND-1:0];
        end
    end

    // [RQ14] Sticky overrun, set wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            overrun_q <= 1'b0;
        end else if (frame_done && !rx_full_n) begin
            overrun_q <= 1'b1;
        end else if (wr_en && avs_address == RAW_COND_ADDR && avs_byteenable[0]
                     && avs_writedata[COND_OVERRUN]) begin
            overrun_q <= 1'b0;
        end
    end

    // [RQ13] Enabled conditions raise request
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(raw_cond & irq_enable_q);
        end
    end

    // ------------------------------------------------------------
    // Bit rate generator
    // ------------------------------------------------------------
    // [RQ7] Half divisor per half bit
    always_ff @(posedge clk) begin
        if (sys_rst || !ctrl_q.enable || pre_tick || start) begin
            pre_cnt_q <= '0;
        end else begin
            pre_cnt_q <= pre_cnt_q + 1'b1;
        end
    end

    assign pre_tick = ctrl_q.enable
                      && (pre_cnt_q + 1'b1 >= prescale_q || prescale_q == '0);

    // [RQ9] Rate factor division
    always_ff @(posedge clk) begin
        if (sys_rst || !ctrl_q.enable || start) begin
            rate_cnt_q <= '0;
        end else if (pre_tick) begin
            rate_cnt_q <= half_tick ? 8'h00 : rate_cnt_q + 1'b1;
        end
    end

    assign half_tick = pre_tick && (rate_cnt_q == ctrl_q.rate);

    // [RQ15] Timeout over 32 bit periods
    always_ff @(posedge clk) begin
        // [RQ18] Restart on access or empty
        if (sys_rst || !rx_out_valid || rx_pop || frame_done) begin
            to_cnt_q <= '0;
        end else if (half_tick && to_cnt_q != 7'(TIMEOUT_TICKS)) begin
            to_cnt_q <= to_cnt_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sck_sync_q <= '0;
            sel_sync_q <= 2'h3;
            din_sync_q <= '0;
        end else begin
            sck_sync_q <= {sck_sync_q[1:0], serial_clk_in};
            sel_sync_q <= {sel_sync_q[0], serial_sel_n_in};
            din_sync_q <= {din_sync_q[0], serial_data_in};
        end
    end

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    assign sel_active = ctrl_q.slave && !sel_sync_q[1];

    // [RQ12] Slave edges from external clock
    always_comb begin
        if (ctrl_q.slave) begin
            rise_ev = sel_active && sck_sync_q[1] && !sck_sync_q[2];
            fall_ev = sel_active && !sck_sync_q[1] && sck_sync_q[2];
        end else begin
            rise_ev = half_tick && !sclk_q;
            fall_ev = half_tick && sclk_q;
        end
    end

    assign start = (state_q == ST_IDLE) && ctrl_q.enable
                   && (ctrl_q.slave ? sel_active : tx_valid);
    assign tx_pop = start && tx_valid;
    assign frame_done = (state_q == ST_SHIFT) && fall_ev
                        && (bit_cnt_q == BW'(DATA_W));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= '0;
            tx_sh_q   <= '0;
            rx_sh_q   <= '0;
            sclk_q    <= 1'b0;
            sel_n_q   <= 1'b1;
            dout_q    <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    sclk_q <= 1'b0;
                    if (start) begin
                        state_q   <= ST_SHIFT;
                        bit_cnt_q <= '0;
                        tx_sh_q   <= tx_valid ? tx_data : '0;
                        dout_q    <= tx_valid ? tx_data[DATA_W-1] : 1'b0;
                        sel_n_q   <= ctrl_q.slave;
                    end
                end
                ST_SHIFT: begin
                    if (!ctrl_q.enable || (ctrl_q.slave && !sel_active)) begin
                        state_q <= ST_IDLE;
                        sel_n_q <= 1'b1;
                        sclk_q  <= 1'b0;
                    end else if (rise_ev) begin
                        sclk_q    <= 1'b1;
                        rx_sh_q   <= {rx_sh_q[DATA_W-2:0], din_sync_q[1]};
                        bit_cnt_q <= bit_cnt_q + 1'b1;
                    end else if (fall_ev) begin
                        sclk_q <= 1'b0;
                        if (frame_done) begin
                            state_q <= ST_IDLE;
                            sel_n_q <= 1'b1;
                        end else begin
                            tx_sh_q <= {tx_sh_q[DATA_W-2:0], 1'b0};
                            dout_q  <= tx_sh_q[DATA_W-2];
                        end
                    end
                end
            endcase
        end
    end

    // Output enables by mode
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clk_oe_q  <= 1'b0;
            data_oe_q <= 1'b0;
        end else begin
            clk_oe_q  <= ctrl_q.enable && !ctrl_q.slave;
            data_oe_q <= ctrl_q.enable && (!ctrl_q.slave || sel_active);
        end
    end

    assign avs_readdata     = rdata_q;
    assign avs_waitrequest  = wait_q;
    assign serial_clk_out   = sclk_q;
    assign serial_clk_oe    = clk_oe_q;
    assign serial_sel_n_out = sel_n_q;
    assign serial_sel_oe    = clk_oe_q;
    assign serial_data_out  = dout_q;
    assign serial_data_oe   = data_oe_q;
    assign irq_request      = irq_q;
endmodule

// ### test/sync_serial_port_sva.sv
// Checker of bus timing, status fields and enable gating at the port pins
module sync_serial_port_sva
    import sync_serial_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic [31:0] avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        tx_in_ready,
    input wire logic        rx_out_valid,
    input wire logic        rx_out_ready,
    input wire logic        serial_sel_n_out,
    input wire logic        serial_sel_oe,
    input wire logic        irq_request
);
    logic [3:0] en_q;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Shadow of the enable register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            en_q <= 4'h0;
        end else if (avs_write && !avs_waitrequest && avs_byteenable[0]
                     && avs_address == IRQ_ENABLE_ADDR) begin
            en_q <= avs_writedata[3:0];
        end
    end
    sequence st_ans;
        !avs_waitrequest && $past(avs_read) && $past(avs_address) == FIFO_STATE_ADDR;
    endsequence
    sequence ps_ans;
        !avs_waitrequest && $past(avs_read) && $past(avs_address) == PRESCALE_ADDR;
    endsequence
    wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("bus answer late");
    answer_once_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer held too long");
    rsvd_zero_a: assert property (st_ans |-> avs_readdata[31:5] == 27'h0)
        else $error("reserved status bits set");
    tx_empty_a: assert property (st_ans ##0 !$past(tx_in_ready)
        |-> !avs_readdata[TX_EMPTY_BIT]) else $error("full fifo reads empty");
    busy_frame_a: assert property (st_ans ##0 !$past(serial_sel_n_out)
        && !$past(serial_sel_n_out, 2) && $past(serial_sel_oe)
        |-> avs_readdata[LINK_BUSY_BIT]) else $error("busy clear during frame");
    lsb_zero_a: assert property (ps_ans |-> avs_readdata[0] == 1'b0
        && avs_readdata[31:8] == 24'h0) else $error("divisor readback wrong");
    irq_enable_a: assert property (irq_request |-> $past(en_q) != 4'h0)
        else $error("interrupt with all enables off");
    rx_hold_a: assert property (rx_out_valid && !rx_out_ready |=> rx_out_valid)
        else $error("receive data lost without read");
endmodule

bind sync_serial_port sync_serial_port_sva i_sync_serial_port_sva (
    .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .tx_in_ready, .rx_out_valid,
    .rx_out_ready, .serial_sel_n_out, .serial_sel_oe, .irq_request
);

// ### test/serial_peer.sv
// Serial slave model replying with a rising byte count per frame
module serial_peer (
    input  wire logic       sclk,
    input  wire logic       sel_n,
    input  wire logic       mosi,
    output logic            miso,
    output logic [7:0]      last_rx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] tx_q  = 8'h00;
    logic [7:0] rx_q  = 8'h00;
    logic [7:0] nxt_q = 8'ha0;
    // Reply loaded as select falls
    always @(negedge sel_n) begin
        tx_q = nxt_q;
        nxt_q = nxt_q + 8'h01;
    end
    always @(posedge sclk) if (!sel_n) rx_q = {rx_q[6:0], mosi};
    always @(negedge sclk) if (!sel_n) tx_q = {tx_q[6:0], 1'b0};
    always @(posedge sel_n) last_rx = rx_q;
    // Released line shows inverse of last bit
    assign miso = sel_n ? ~tx_q[7] : tx_q[7];
endmodule

// ### test/sync_serial_port_tb.sv
// Register, stream and serial link tests of the synchronous serial port
module sync_serial_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import sync_serial_pkg::*;
    localparam logic [31:0] DIV  = 32'h4;
    localparam logic [31:0] RATE = 32'h1;
    logic        clk, sys_rst, avs_read, avs_write, tx_in_valid, rx_out_ready;
    logic        avs_waitrequest, tx_in_ready, rx_out_valid, irq_request;
    logic        sck, sck_oe, sel_n, sel_oe, sdo, sdo_oe, miso, sclk, sel_w, mosi;
    logic [31:0] avs_address, avs_writedata, avs_readdata, rd;
    logic [7:0]  tx_in_data, rx_out_data, peer_rx;
    int          num_errors, samples_checked, cyc;
    time         t0;
    assign sclk = sck_oe ? sck : 1'b0;
    assign sel_w = sel_oe ? sel_n : 1'b1;
    assign mosi = sdo_oe ? sdo : 1'b0;
    sync_serial_port #(.DATA_W(8), .DEPTH(8)) i_sync_serial_port (
        .clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready), .tx_in_data(tx_in_data),
        .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
        .rx_out_data(rx_out_data), .serial_clk_in(sclk), .serial_clk_out(sck),
        .serial_clk_oe(sck_oe), .serial_sel_n_in(sel_w), .serial_sel_n_out(sel_n),
        .serial_sel_oe(sel_oe), .serial_data_in(miso), .serial_data_out(sdo),
        .serial_data_oe(sdo_oe), .irq_request(irq_request));
    serial_peer i_serial_peer (.sclk(sclk), .sel_n(sel_w), .mosi(mosi), .miso(miso),
        .last_rx(peer_rx));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic give_verdict;
        $display("mismatches %0d of %0d checks", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic push(input logic [7:0] d);
        @(posedge clk);
        tx_in_valid <= 1'b1;
        tx_in_data <= d;
        do @(posedge clk); while (tx_in_ready !== 1'b1);
        tx_in_valid <= 1'b0;
    endtask
    task automatic pop;
        @(posedge clk);
        rx_out_ready <= 1'b1;
        do @(posedge clk); while (rx_out_valid !== 1'b1);
        rd = {24'h0, rx_out_data};
        rx_out_ready <= 1'b0;
    endtask
    task automatic wait_idle;
        do bus(1'b0, FIFO_STATE_ADDR, 32'h0); while (rd[LINK_BUSY_BIT] !== 1'b0);
    endtask
    initial begin
        {sys_rst, avs_read, avs_write, tx_in_valid, rx_out_ready} = 5'h10;
        {avs_address, avs_writedata, tx_in_data} = '0;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        rdchk(FIFO_STATE_ADDR, 32'h3);
        rdchk(PRESCALE_ADDR, 32'h0);
        rdchk(IRQ_ENABLE_ADDR, 32'h0);
        rdchk(RAW_COND_ADDR, 32'h8);
        rdchk(32'h4004_0020, 32'h0);
        bus(1'b1, FIFO_STATE_ADDR, 32'hffff_ffff);
        rdchk(FIFO_STATE_ADDR, 32'h3);
        bus(1'b1, PRESCALE_ADDR, 32'hff);
        rdchk(PRESCALE_ADDR, 32'hfe);
        bus(1'b1, PRESCALE_ADDR, DIV | 32'h1);
        rdchk(PRESCALE_ADDR, DIV);
        bus(1'b1, IRQ_ENABLE_ADDR, 32'hf);
        rdchk(IRQ_ENABLE_ADDR, 32'hf);
        for (int i = 0; i < 8; i++) push(8'h30 + 8'(i));
        @(posedge clk) chk({31'h0, tx_in_ready}, 32'h0);
        rdchk(FIFO_STATE_ADDR, 32'h10);
        rdchk(RAW_COND_ADDR, 32'h0);
        bus(1'b1, CTRL_ZERO_ADDR, (RATE << CTRL_RATE_LSB) | 32'h1);
        @(posedge sclk) t0 = $time;
        @(posedge sclk) chk(32'(($time - t0) / 20), DIV * (RATE + 1));
        wait_idle();
        rdchk(FIFO_STATE_ADDR, 32'hf);
        bus(1'b0, RAW_COND_ADDR, 32'h0);
        chk(rd & 32'hd, 32'hc);
        chk({31'h0, irq_request}, 32'h1);
        push(8'h5a);
        wait_idle();
        chk({24'h0, peer_rx}, 32'h5a);
        bus(1'b0, RAW_COND_ADDR, 32'h0);
        chk(rd & 32'h1, 32'h1);
        for (int i = 0; i < 8; i++) begin
            pop();
            chk(rd, (i < 7) ? 32'ha0 + 32'(i) : 32'ha8);
        end
        bus(1'b1, RAW_COND_ADDR, 32'h1);
        push(8'h3c);
        wait_idle();
        bus(1'b0, RAW_COND_ADDR, 32'h0);
        chk(rd & 32'h3, 32'h0);
        repeat (300) @(posedge clk);
        bus(1'b0, RAW_COND_ADDR, 32'h0);
        chk(rd & 32'h2, 32'h2);
        bus(1'b1, CTRL_ZERO_ADDR, 32'h3);
        rdchk(FIFO_STATE_ADDR, 32'h7);
        bus(1'b1, IRQ_ENABLE_ADDR, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, irq_request}, 32'h0);
        give_verdict();
    end
endmodule
